// ===== rtl/dep_eeprom_ctrl.sv
`timescale 1ns/1ns
`include "dep_defs.svh"
module dep_eeprom_ctrl
  import dep_pkg::*;
#(
  parameter int PROG_CYCLES = `DEP_PROG_CYCLES
) (
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic [11:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  input wire logic dbg_access_i,
  input wire logic rop_enable_i,
  input wire logic rop_remove_i,
  input wire logic wfi_i,
  input wire logic active_halt_i,
  input wire logic halt_i,
  output logic ee_busy_o,
  output logic ee_wait_o,
  output logic ee_halt_o,
  output logic pgm_erase_o
);

  // --------------------------------------------------------------------------
  // Declarations
  // --------------------------------------------------------------------------

  dep_state_t state_q, state_d;
  logic [1:0] acc_cnt_q;
  logic [31:0] rdata_q;
  logic write_collect_mode_bit_q;
  logic cell_burn_go_bit_q;
  logic [2:0] row_q;
  logic [`DEP_ROW_BYTES-1:0] valid_q;
  logic [8:0] step_q;
  logic [15:0] timer_q;
  logic req, acc_done, sel_csr, sel_win, blocked;
  logic csr_wr, win_wr, start, sw_lat_clr, sw_abort, halt_abort, prog_done, lat_fall;
  logic sleep_req, engine_busy;
  logic [4:0] lat_idx, burn_idx;
  logic [7:0] latch_q, arr_q, lat_wdata, arr_wdata, rd_byte, csr_value;
  logic [7:0] arr_addr;
  logic arr_we;
  logic [15:0] timer_last;

  // Index of the byte just read from the latches during a burn.
  function automatic logic [4:0] prev_idx(input logic [8:0] s);
    logic [8:0] p;
    p = s - 9'h001;
    return p[4:0];
  endfunction : prev_idx

  assign timer_last = 16'(PROG_CYCLES - 1);

  // --------------------------------------------------------------------------
  // Avalon-MM slave
  // --------------------------------------------------------------------------

  // Every access answers on its third cycle, so the arrays have time to read.
  assign req = avs_read_i | avs_write_i;
  assign avs_waitrequest_o = req && (acc_cnt_q != `DEP_BUS_LAT);
  assign acc_done = req && (acc_cnt_q == `DEP_BUS_LAT);

  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      acc_cnt_q <= 2'h0;
    end
    else if (!req || acc_done)
    begin
      acc_cnt_q <= 2'h0;
    end
    else
    begin
      acc_cnt_q <= acc_cnt_q + 2'h1;
    end
  end

  // Address decode; anything else reads zero and ignores writes.
  assign sel_csr = (avs_address_i == `DEP_CSR_OFS);
  assign sel_win = (avs_address_i[11:10] == `DEP_WIN_SEL) && (avs_address_i[1:0] == 2'h0);
  assign blocked = dbg_access_i && rop_enable_i;

  assign csr_wr = avs_write_i && acc_done && sel_csr && avs_byteenable_i[0];
  // Array writes are captured only in write-collect mode and outside a burn.
  assign win_wr = avs_write_i && acc_done && sel_win && avs_byteenable_i[0] && !blocked
                  && write_collect_mode_bit_q && !cell_burn_go_bit_q;

  // Only the two control bits exist; the rest reads zero.
  assign csr_value = {6'h00, write_collect_mode_bit_q, cell_burn_go_bit_q};

  // Read mux; the latches have no path here at all.
  always_comb
  begin
    rd_byte = 8'h00;
    if (sel_csr)
    begin
      rd_byte = csr_value;
    end
    else if (sel_win && !write_collect_mode_bit_q && !blocked)
    begin
      rd_byte = arr_q;
    end
  end

  // Read data are captured one cycle before the answer and held till the next.
  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      rdata_q <= 32'h0000_0000;
    end
    else if (avs_read_i && acc_cnt_q == 2'h1)
    begin
      rdata_q <= {24'h00_0000, rd_byte};
    end
  end

  assign avs_readdata_o = rdata_q;

  // --------------------------------------------------------------------------
  // Control/status register
  // --------------------------------------------------------------------------

  assign start = csr_wr && avs_writedata_i[`DEP_CSR_PGM_BIT] && write_collect_mode_bit_q
                 && !cell_burn_go_bit_q && !blocked && (state_q == DEP_ST_IDLE);
  assign sw_lat_clr = csr_wr && !avs_writedata_i[`DEP_CSR_LAT_BIT] && !cell_burn_go_bit_q;
  // Clearing program-start mid-cycle stops the burn; cell contents are then undefined.
  assign sw_abort = csr_wr && !avs_writedata_i[`DEP_CSR_PGM_BIT] && cell_burn_go_bit_q;
  assign halt_abort = halt_i && (state_q != DEP_ST_HALT);
  assign prog_done = (state_q == DEP_ST_TIMER) && (timer_q == timer_last) && !halt_i
                     && !sw_abort;
  assign lat_fall = write_collect_mode_bit_q && (halt_abort || prog_done || sw_lat_clr);

  // Write-collect mode bit: software sets, cycle end, halt or software clears.
  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      write_collect_mode_bit_q <= 1'b0;
    end
    else if (halt_abort || prog_done || sw_lat_clr)
    begin
      write_collect_mode_bit_q <= 1'b0;
    end
    else if (csr_wr && avs_writedata_i[`DEP_CSR_LAT_BIT])
    begin
      write_collect_mode_bit_q <= 1'b1;
    end
  end

  // Program-start bit doubles as the in-progress flag.
  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      cell_burn_go_bit_q <= 1'b0;
    end
    else if (halt_abort || prog_done || sw_abort)
    begin
      cell_burn_go_bit_q <= 1'b0;
    end
    else if (start && !rop_remove_i)
    begin
      cell_burn_go_bit_q <= 1'b1;
    end
  end

  // --------------------------------------------------------------------------
  // Row data latches
  // --------------------------------------------------------------------------

  assign lat_idx = avs_address_i[6:2];
  assign burn_idx = step_q[4:0];

  // A second write into a filled latch keeps only bits that are zero in either.
  assign lat_wdata = valid_q[lat_idx] ? (latch_q & avs_writedata_i[7:0])
                                      : avs_writedata_i[7:0];

  // Valid mask empties at cycle end or when write-collect mode falls.
  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      valid_q <= '0;
    end
    else if (lat_fall || prog_done)
    begin
      valid_q <= '0;
    end
    else if (win_wr)
    begin
      valid_q[lat_idx] <= 1'b1;
    end
  end

  // The row of the most recent captured write is the one burned.
  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      row_q <= 3'h0;
    end
    else if (win_wr)
    begin
      row_q <= avs_address_i[9:7];
    end
  end

  dep_mem #(
    .AW(5)
  ) u_latches (
    .clk_i(clk_i),
    .arst_n_i(arst_n_i),
    .we_i(win_wr),
    .addr_i((state_q == DEP_ST_BURN) ? burn_idx : lat_idx),
    .wdata_i(lat_wdata),
    .rdata_o(latch_q)
  );

  // --------------------------------------------------------------------------
  // Programming engine
  // --------------------------------------------------------------------------

  assign sleep_req = wfi_i || active_halt_i;
  assign engine_busy = (state_q == DEP_ST_BURN) || (state_q == DEP_ST_ERASE);

  // Next state; halt overrides everything and drops any running work.
  always_comb
  begin
    state_d = state_q;
    case (state_q)
      DEP_ST_IDLE:
      begin
        if (rop_remove_i)
        begin
          state_d = DEP_ST_ERASE;
        end
        else if (start)
        begin
          state_d = DEP_ST_BURN;
        end
        else if (sleep_req)
        begin
          state_d = DEP_ST_WAIT;
        end
      end
      DEP_ST_BURN:
      begin
        if (sw_abort)
        begin
          state_d = DEP_ST_IDLE;
        end
        else if (step_q == 9'(`DEP_ROW_BYTES))
        begin
          state_d = DEP_ST_TIMER;
        end
      end
      DEP_ST_TIMER:
      begin
        if (sw_abort)
        begin
          state_d = DEP_ST_IDLE;
        end
        else if (prog_done)
        begin
          state_d = sleep_req ? DEP_ST_WAIT : DEP_ST_IDLE;
        end
      end
      DEP_ST_ERASE:
      begin
        if (step_q == `DEP_ARR_LAST)
        begin
          state_d = sleep_req ? DEP_ST_WAIT : DEP_ST_IDLE;
        end
      end
      DEP_ST_WAIT:
      begin
        if (!sleep_req)
        begin
          state_d = DEP_ST_IDLE;
        end
      end
      DEP_ST_HALT:
      begin
        if (!halt_i)
        begin
          state_d = DEP_ST_IDLE;
        end
      end
      default:
      begin
        state_d = DEP_ST_IDLE;
      end
    endcase
    if (halt_abort)
    begin
      state_d = DEP_ST_HALT;
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      state_q <= DEP_ST_IDLE;
    end
    else
    begin
      state_q <= state_d;
    end
  end

  // Byte step for burn and erase walks.
  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      step_q <= 9'h000;
    end
    else if (engine_busy && state_d == state_q)
    begin
      step_q <= step_q + 9'h001;
    end
    else
    begin
      step_q <= 9'h000;
    end
  end

  // Cell cycle duration counted in clocks, no software timing needed.
  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      timer_q <= 16'h0000;
    end
    else if (state_q == DEP_ST_TIMER && state_d == DEP_ST_TIMER)
    begin
      timer_q <= timer_q + 16'h0001;
    end
    else
    begin
      timer_q <= 16'h0000;
    end
  end

  // --------------------------------------------------------------------------
  // Cell array
  // --------------------------------------------------------------------------

  // Burn writes each filled latch, one step behind its read; erase fills ones.
  always_comb
  begin
    arr_we = 1'b0;
    arr_addr = avs_address_i[9:2];
    arr_wdata = latch_q;
    if (state_q == DEP_ST_BURN)
    begin
      arr_addr = {row_q, prev_idx(step_q)};
      arr_we = (step_q != 9'h000) && valid_q[prev_idx(step_q)] && !halt_i;
    end
    else if (state_q == DEP_ST_ERASE)
    begin
      arr_addr = step_q[7:0];
      arr_wdata = `DEP_ERASED_BYTE;
      arr_we = !halt_i;
    end
  end

  dep_mem #(
    .AW(8)
  ) u_array (
    .clk_i(clk_i),
    .arst_n_i(arst_n_i),
    .we_i(arr_we),
    .addr_i(arr_addr),
    .wdata_i(arr_wdata),
    .rdata_o(arr_q)
  );

  // --------------------------------------------------------------------------
  // Status outputs
  // --------------------------------------------------------------------------

  assign ee_busy_o = cell_burn_go_bit_q;
  assign ee_wait_o = (state_q == DEP_ST_WAIT);
  assign ee_halt_o = (state_q == DEP_ST_HALT);
  assign pgm_erase_o = (state_q == DEP_ST_ERASE);

endmodule : dep_eeprom_ctrl

// ===== rtl/dep_mem.sv
`timescale 1ns/1ns
// Single-port byte memory with registered read data.
module dep_mem #(
  parameter int AW = 8
) (
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic we_i,
  input wire logic [AW-1:0] addr_i,
  input wire logic [7:0] wdata_i,
  output logic [7:0] rdata_o
);

  logic [7:0] mem [0:(1<<AW)-1];

  // Write port; the array itself carries no reset.
  always_ff @(posedge clk_i)
  begin
    if (we_i)
    begin
      mem[addr_i] <= wdata_i;
    end
  end

  // Read data leaves through a register every cycle.
  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      rdata_o <= 8'h00;
    end
    else
    begin
      rdata_o <= mem[addr_i];
    end
  end

endmodule : dep_mem

// ===== shared/dep_defs.svh
`ifndef DEP_DEFS_SVH
`define DEP_DEFS_SVH

// ----------------------------------------------------------------------------
// Register map
// ----------------------------------------------------------------------------

// Control/status register byte address.
`define DEP_CSR_OFS 12'h030
// EEPROM window: address bits 11:10 equal to this value, one byte per word.
`define DEP_WIN_SEL 2'h1
// Control/status bit positions and reset value.
`define DEP_CSR_LAT_BIT 1
`define DEP_CSR_PGM_BIT 0
`define DEP_CSR_RESET 8'h00

// ----------------------------------------------------------------------------
// Array geometry and timing
// ----------------------------------------------------------------------------

// Bytes in one row, the number of row data latches.
`define DEP_ROW_BYTES 32
// Last row latch index.
`define DEP_ROW_LAST 9'h01F
// Last byte address of the array.
`define DEP_ARR_LAST 9'h0FF
// Value of an erased cell.
`define DEP_ERASED_BYTE 8'hFF
// Bus answer latency: waitrequest drops on this access count.
`define DEP_BUS_LAT 2'h2
// Programming cycle duration and the clock period, both in ns.
`define DEP_PROG_TIME_NS 20000
`define DEP_CLK_PERIOD_NS 8
// Least time rounded up to whole clock cycles.
`define DEP_PROG_CYCLES ((`DEP_PROG_TIME_NS + `DEP_CLK_PERIOD_NS - 1) / `DEP_CLK_PERIOD_NS)

`endif

// ===== shared/dep_pkg.sv
package dep_pkg;

  // Programming engine states, one-hot.
  typedef enum logic [5:0] {
    DEP_ST_IDLE  = 6'h01,
    DEP_ST_BURN  = 6'h02,
    DEP_ST_TIMER = 6'h04,
    DEP_ST_ERASE = 6'h08,
    DEP_ST_WAIT  = 6'h10,
    DEP_ST_HALT  = 6'h20
  } dep_state_t;

endpackage : dep_pkg

// ===== tb/dep_cpu_model.sv
`timescale 1ns/1ns
// ---------
// CPU model
// ---------
module dep_cpu_model (
  input wire logic clk_i,
  input wire logic [31:0] rdata_i,
  input wire logic wait_i,
  output logic [11:0] addr_o,
  output logic rd_o,
  output logic wr_o,
  output logic [31:0] wdata_o,
  output logic [3:0] be_o,
  output logic hung_o
);
  // Idle bus at time zero.
  initial
  begin
    addr_o = 12'h000;
    rd_o = 1'b0;
    wr_o = 1'b0;
    wdata_o = 32'h0000_0000;
    be_o = 4'h1;
    hung_o = 1'b0;
  end
  // One bus cycle; never aimed at code being run from the array, nor clearing
  // program-start mid-cycle unless a test means to.
  task automatic xfer(input logic w, input logic [11:0] a, input logic [7:0] d,
                      output logic [7:0] q);
    int n;
    n = 0;
    // Request, direction and data rise together right after a rising edge.
    addr_o <= a;
    wr_o <= w;
    rd_o <= !w;
    wdata_o <= {24'h000000, d};
    @(posedge clk_i);
    // Hold everything until the rising edge at which waitrequest is seen low.
    while (wait_i !== 1'b0 && n < 64)
    begin
      n++;
      @(posedge clk_i);
    end
    hung_o <= (n >= 64);
    // Read data are taken at that same edge, then the request is released.
    q = rdata_i[7:0];
    rd_o <= 1'b0;
    wr_o <= 1'b0;
    addr_o <= ~a;
    wdata_o <= {24'hFFFFFF, ~d};
    @(posedge clk_i);
  endtask : xfer
endmodule : dep_cpu_model

// ===== tb/dep_eeprom_ctrl_test.sv
`timescale 1ns/1ns
`include "dep_defs.svh"
module dep_eeprom_ctrl_test;
  typedef struct packed {logic w; logic [11:0] a; logic [7:0] d; logic [7:0] e;} dep_row_t;
  localparam logic [11:0] CSR = `DEP_CSR_OFS;
  logic clk = 1'b0;
  logic arst_n;
  logic [11:0] addr;
  logic rd, wr, dbg, rop_en, rop_rm, wait_for_interrupt_instr, ahalt, halt, busy, ewait, ehalt, erase, hung;
  logic [31:0] wdata, rdata;
  logic [3:0] be;
  logic wreq;
  int bad_count = 0;
  int check_count = 0;
  dep_row_t rows [14] = '{
    {1'b0, CSR, 8'h00, 8'h00}, {1'b1, CSR, 8'hFC, 8'h00},
    {1'b0, CSR, 8'h00, 8'h00}, {1'b0, 12'h010, 8'h00, 8'h00},
    {1'b0, 12'h400, 8'h00, 8'hFF}, {1'b1, 12'h404, 8'h55, 8'h00},
    {1'b0, 12'h404, 8'h00, 8'hFF}, {1'b1, CSR, 8'h01, 8'h00},
    {1'b0, CSR, 8'h00, 8'h00}, {1'b1, CSR, 8'h02, 8'h00},
    {1'b0, CSR, 8'h00, 8'h02}, {1'b0, 12'h404, 8'h00, 8'h00},
    {1'b1, CSR, 8'h00, 8'h00}, {1'b0, CSR, 8'h00, 8'h00}};
  // Clock at 125 MHz.
  always #4 clk = ~clk;
  dep_cpu_model cpu_u (.clk_i(clk), .rdata_i(rdata), .wait_i(wreq), .addr_o(addr),
    .rd_o(rd), .wr_o(wr), .wdata_o(wdata), .be_o(be), .hung_o(hung));
  dep_eeprom_ctrl #(.PROG_CYCLES(4)) dut_u (.clk_i(clk), .arst_n_i(arst_n),
    .avs_address_i(addr), .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wdata),
    .avs_byteenable_i(be), .avs_readdata_o(rdata), .avs_waitrequest_o(wreq),
    .dbg_access_i(dbg), .rop_enable_i(rop_en), .rop_remove_i(rop_rm), .wfi_i(wait_for_interrupt_instr),
    .active_halt_i(ahalt), .halt_i(halt), .ee_busy_o(busy), .ee_wait_o(ewait),
    .ee_halt_o(ehalt), .pgm_erase_o(erase));
  // -------------
  // Bench helpers
  // -------------
  task automatic results();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : results
  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp)
    begin
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
      bad_count++;
    end
  endtask : chk_byte
  task automatic chk_flag(input logic got, input logic exp);
    chk_byte({7'h00, got}, {7'h00, exp});
  endtask : chk_flag
  task automatic xf(input logic w, input logic [11:0] a, input logic [7:0] d,
                    input logic [7:0] e);
    logic [7:0] q;
    cpu_u.xfer(w, a, d, q);
    if (hung !== 1'b0)
    begin
      bad_count++;
      results();
    end
    if (!w)
      chk_byte(q, e);
  endtask : xf
  task automatic settle();
    int n;
    n = 0;
    @(negedge clk);
    while ((busy !== 1'b0 || erase !== 1'b0) && n < 2000)
    begin
      n++;
      @(negedge clk);
    end
    if (n >= 2000)
    begin
      bad_count++;
      results();
    end
    @(posedge clk);
  endtask : settle
  // Arms a cycle on a row 2 byte: write-collect mode, one latch write, then program-start.
  task automatic arm(input logic [11:0] a, input logic [7:0] d);
    xf(1'b1, CSR, 8'h02, 8'h00);
    xf(1'b1, a, d, 8'h00);
    xf(1'b1, CSR, 8'h03, 8'h00);
  endtask : arm
  // -------------
  // Main sequence
  // -------------
  initial
  begin
    {arst_n, dbg, rop_en, rop_rm, wait_for_interrupt_instr, ahalt, halt} = 7'h00;
    repeat (16) @(posedge clk);
    arst_n <= 1'b1;
    @(posedge clk);
    rop_rm <= 1'b1;
    @(posedge clk);
    rop_rm <= 1'b0;
    settle();
    foreach (rows[i])
      xf(rows[i].w, rows[i].a, rows[i].d, rows[i].e);
    $display("table done");
    xf(1'b1, CSR, 8'h02, 8'h00);
    xf(1'b1, 12'h500, 8'hF0, 8'h00);
    xf(1'b1, 12'h504, 8'h3C, 8'h00);
    xf(1'b1, 12'h500, 8'h0F, 8'h00);
    arm(12'h57C, 8'hA5);
    xf(1'b0, CSR, 8'h00, 8'h03);
    wait_for_interrupt_instr <= 1'b1;
    @(posedge clk);
    chk_flag(ewait, 1'b0);
    settle();
    @(posedge clk);
    chk_flag(ewait, 1'b1);
    wait_for_interrupt_instr <= 1'b0;
    repeat (2) @(posedge clk);
    xf(1'b0, CSR, 8'h00, 8'h00);
    xf(1'b0, 12'h500, 8'h00, 8'h00);
    xf(1'b0, 12'h504, 8'h00, 8'h3C);
    xf(1'b0, 12'h57C, 8'h00, 8'hA5);
    xf(1'b0, 12'h508, 8'h00, 8'hFF);
    $display("program done");
    xf(1'b1, CSR, 8'h02, 8'h00);
    xf(1'b1, 12'h518, 8'h12, 8'h00);
    xf(1'b1, CSR, 8'h00, 8'h00);
    arm(12'h51C, 8'h34);
    settle();
    xf(1'b0, 12'h518, 8'h00, 8'hFF);
    xf(1'b0, 12'h51C, 8'h00, 8'h34);
    $display("latch clear done");
    arm(12'h520, 8'h00);
    halt <= 1'b1;
    repeat (2) @(posedge clk);
    chk_flag(ehalt, 1'b1);
    chk_flag(busy, 1'b0);
    halt <= 1'b0;
    repeat (2) @(posedge clk);
    xf(1'b0, CSR, 8'h00, 8'h00);
    arm(12'h524, 8'h00);
    arst_n <= 1'b0;
    repeat (2) @(posedge clk);
    arst_n <= 1'b1;
    @(posedge clk);
    xf(1'b0, CSR, 8'h00, 8'h00);
    $display("abort done");
    {rop_en, dbg} <= 2'h3;
    xf(1'b0, 12'h504, 8'h00, 8'h00);
    arm(12'h504, 8'h00);
    xf(1'b0, CSR, 8'h00, 8'h02);
    xf(1'b1, CSR, 8'h00, 8'h00);
    {rop_en, dbg} <= 2'h1;
    xf(1'b0, 12'h504, 8'h00, 8'h3C);
    rop_en <= 1'b0;
    ahalt <= 1'b1;
    repeat (2) @(posedge clk);
    chk_flag(ewait, 1'b1);
    ahalt <= 1'b0;
    $display("protect and wait done");
    results();
  end
endmodule : dep_eeprom_ctrl_test

// ===== tb/dep_eeprom_props.sv
`timescale 1ns/1ns
`include "dep_defs.svh"
// -------
// Checker
// -------
module dep_eeprom_props #(
  parameter int PROG_CYCLES = 4
) (
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic [11:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [31:0] avs_readdata_o,
  input wire logic avs_waitrequest_o,
  input wire logic rop_remove_i,
  input wire logic wfi_i,
  input wire logic active_halt_i,
  input wire logic halt_i,
  input wire logic ee_busy_o,
  input wire logic ee_wait_o,
  input wire logic ee_halt_o,
  input wire logic pgm_erase_o
);
  logic [15:0] busy_cnt_q;
  logic csr_wr;
  logic csr_rd;
  // Answered control/status accesses.
  assign csr_wr = avs_write_i && !avs_waitrequest_o && avs_address_i == `DEP_CSR_OFS;
  assign csr_rd = avs_read_i && !avs_waitrequest_o && avs_address_i == `DEP_CSR_OFS;
  // Counts how long program-start has stood.
  always_ff @(posedge clk_i or negedge arst_n_i)
    if (!arst_n_i)
      busy_cnt_q <= 16'h0000;
    else
      busy_cnt_q <= ee_busy_o ? busy_cnt_q + 16'h0001 : 16'h0000;
  default clocking dep_cb @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);
  sequence req_rise_s; $rose(avs_read_i || avs_write_i); endsequence
  sequence two_wait_s; avs_waitrequest_o ##1 avs_waitrequest_o ##1 !avs_waitrequest_o; endsequence
  bus_answer_a: assert property (req_rise_s |-> two_wait_s)
    else $error("bus answer not in third cycle");
  csr_zero_a: assert property (csr_rd |-> avs_readdata_o[31:2] == 30'h0)
    else $error("reserved status bits not zero");
  busy_read_a: assert property (csr_rd && ee_busy_o && $past(ee_busy_o) |-> avs_readdata_o[0])
    else $error("program-start reads zero while busy");
  start_cause_a: assert property ($rose(ee_busy_o) |-> $past(csr_wr && avs_writedata_i[0]))
    else $error("cycle started without a start write");
  busy_min_a: assert property ($fell(ee_busy_o) && !$past(halt_i) && !$past(csr_wr)
    |-> $past(busy_cnt_q) >= PROG_CYCLES)
    else $error("programming cycle too short");
  halt_stop_a: assert property (halt_i |=> ee_halt_o && !ee_busy_o && !pgm_erase_o)
    else $error("halt not entered at once");
  wait_idle_a: assert property ((wfi_i || active_halt_i) && !ee_busy_o && !pgm_erase_o && !ee_halt_o
    && !halt_i && !rop_remove_i && !avs_write_i |=> ee_wait_o)
    else $error("idle wait not entered");
  busy_nowait_a: assert property (ee_busy_o |-> !ee_wait_o)
    else $error("wait entered during a cycle");
  erase_cause_a: assert property ($rose(pgm_erase_o) |-> $past(rop_remove_i))
    else $error("erase without option removal");
  erase_hold_a: assert property ($rose(pgm_erase_o) |-> pgm_erase_o[*8])
    else $error("erase walk cut short");
endmodule : dep_eeprom_props

bind dep_eeprom_ctrl dep_eeprom_props #(.PROG_CYCLES(PROG_CYCLES)) props_u (
  .clk_i(clk_i), .arst_n_i(arst_n_i), .avs_address_i(avs_address_i),
  .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
  .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
  .rop_remove_i(rop_remove_i), .wfi_i(wfi_i), .active_halt_i(active_halt_i),
  .halt_i(halt_i), .ee_busy_o(ee_busy_o), .ee_wait_o(ee_wait_o), .ee_halt_o(ee_halt_o),
  .pgm_erase_o(pgm_erase_o));
